// >>> logic/gpg_defines.vh
// How it works
// - each pin has a software direction bit, changeable at any time
// - reset makes all pins inputs and disables every pin interrupt
// - set and clear writes change only the selected output bits
// - one write updates the whole output value of a port
// - each pin has its own word: read gives level, write drives output
// - pin interrupts trigger on level, rising, falling or both edges
// - eight pin interrupt channels, each picks any pin as source
// - two group units combine enabled pins into one request each
// - any pin or combination of pins of each port may trigger a group
// - pins not owned by a peripheral are driven and sensed by this block
// - registers sit on a dedicated zero-wait slave port
// - only the address bits of the 16 kB window are decoded
`ifndef GPG_DEFINES_VH
`define GPG_DEFINES_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define GPG_NPIN 64
`define GPG_AW 14
`define GPG_NCHAN 8
`define GPG_NGRP 2

// ----------------------------------------------------------------
// register offsets, byte addresses inside the window
// ----------------------------------------------------------------
`define GPG_PIN_PAGE 6'h10
`define GPG_DIR0 14'h2000
`define GPG_DIR1 14'h2004
`define GPG_OUT0 14'h2100
`define GPG_OUT1 14'h2104
`define GPG_LVL0 14'h2200
`define GPG_LVL1 14'h2204
`define GPG_SET0 14'h2300
`define GPG_SET1 14'h2304
`define GPG_CLR0 14'h2380
`define GPG_CLR1 14'h2384
`define GPG_PINT_PAGE 9'h180
`define GPG_STAT 14'h3040
`define GPG_STCLR 14'h3044
`define GPG_IEN 14'h3048
`define GPG_GRP_PAGE 9'h188

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GPG_CFG_SEL_HI 5
`define GPG_CFG_EN 8
`define GPG_CFG_LVL 9
`define GPG_CFG_RISE 10
`define GPG_CFG_FALL 11
`define GPG_CFG_W 12
`define GPG_CFG_RST 12'h000
`define GPG_NSTAT 10
`define GPG_STAT_RST 10'h000
`define GPG_WORD_RST 32'h0000_0000
`define GPG_PIN_RST 64'h0000_0000_0000_0000

`endif

// >>> logic/gpg_pint_chan.v
`timescale 1ns/1ps
`include "gpg_defines.vh"
module gpg_pint_chan
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // source pin and configuration
   input wire lvl,
   input wire [`GPG_CFG_W-1:0] cfg,
   // flag handling
   input wire clr,
   output wire flag
);

   reg prev_ff;
   reg flag_ff;
   reg set;
   reg nxt_flag;

   wire en = cfg[`GPG_CFG_EN];
   wire rise = cfg[`GPG_CFG_RISE];
   wire fall = cfg[`GPG_CFG_FALL];

   always @*
   begin
      set = 1'b0;
      if (en)
      begin
         if (cfg[`GPG_CFG_LVL])
            set = (rise & lvl) | (fall & ~lvl);
         else
            set = (rise & lvl & ~prev_ff) | (fall & ~lvl & prev_ff);
      end
      // set wins over a clear in the same cycle
      nxt_flag = set | (flag_ff & ~clr);
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         prev_ff <= 1'b0;
         flag_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= lvl;
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;

endmodule

// >>> logic/gpg_sync.v
`timescale 1ns/1ps
// two-flop synchroniser; stage one feeds only stage two
module gpg_sync
#(
   parameter W = 64
)
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // data
   input wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end
      else
      begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule

// >>> logic/gpg_top.v
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "gpg_defines.vh"
module gpg_top
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // register port
   input wire [`GPG_AW-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output wire [31:0] rdata,
   // pins
   input wire [`GPG_NPIN-1:0] pad_in,
   input wire [`GPG_NPIN-1:0] periph_own,
   output wire [`GPG_NPIN-1:0] pad_out,
   output wire [`GPG_NPIN-1:0] pad_oe_b,
   // interrupts
   output wire [`GPG_NCHAN-1:0] pint_irq,
   output wire [`GPG_NGRP-1:0] grp_irq,
   output wire irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [`GPG_NPIN-1:0] dir_ff;
   reg [`GPG_NPIN-1:0] nxt_dir;
   reg [`GPG_NPIN-1:0] out_ff;
   reg [`GPG_NPIN-1:0] nxt_out;
   reg [`GPG_NSTAT-1:0] ien_ff;
   reg [`GPG_NSTAT-1:0] nxt_ien;
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;

   wire [`GPG_NPIN-1:0] lvl;
   wire [`GPG_NCHAN-1:0] pint_flag;
   wire [`GPG_NGRP-1:0] grp_flag;
   wire [`GPG_NSTAT-1:0] stat;
   wire [`GPG_NSTAT-1:0] stat_clr;
   wire [`GPG_CFG_W*`GPG_NCHAN-1:0] cfg_flat;
   wire [32*`GPG_NGRP-1:0] grp_ctrl_rd;
   wire [32*`GPG_NGRP-1:0] grp_hit_rd;

   // only the window bits reach the decoder
   wire pin_page = (addr[13:8] == `GPG_PIN_PAGE);
   wire [5:0] pin_idx = addr[7:2];
   wire pint_page = (addr[13:5] == `GPG_PINT_PAGE);
   wire [2:0] pint_idx = addr[4:2];

   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   // all sensing below sees only the second stage
   gpg_sync #(.W(`GPG_NPIN)) u_sync
   (
      .clk(clk),
      .rst_b(rst_b),
      .d(pad_in),
      .q(lvl)
   );

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // a pin owned by a peripheral is released so its function wins
   assign pad_out = out_ff;
   assign pad_oe_b = ~(dir_ff & ~periph_own);

   // ----------------------------------------------------------------
   // direction and output registers
   // ----------------------------------------------------------------
   always @*
   begin
      nxt_dir = dir_ff;
      nxt_out = out_ff;
      nxt_ien = ien_ff;
      if (wr)
      begin
         case (addr)
            `GPG_DIR0: nxt_dir[31:0] = wdata;
            `GPG_DIR1: nxt_dir[63:32] = wdata;
            `GPG_OUT0: nxt_out[31:0] = wdata;
            `GPG_OUT1: nxt_out[63:32] = wdata;
            `GPG_SET0: nxt_out[31:0] = out_ff[31:0] | wdata;
            `GPG_SET1: nxt_out[63:32] = out_ff[63:32] | wdata;
            `GPG_CLR0: nxt_out[31:0] = out_ff[31:0] & ~wdata;
            `GPG_CLR1: nxt_out[63:32] = out_ff[63:32] & ~wdata;
            `GPG_IEN: nxt_ien = wdata[`GPG_NSTAT-1:0];
            default:
            begin
               if (pin_page)
                  nxt_out[pin_idx] = wdata[0];
            end
         endcase
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         dir_ff <= `GPG_PIN_RST;
         out_ff <= `GPG_PIN_RST;
         ien_ff <= `GPG_STAT_RST;
      end
      else
      begin
         dir_ff <= nxt_dir;
         out_ff <= nxt_out;
         ien_ff <= nxt_ien;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   assign stat = {grp_flag, pint_flag};
   assign stat_clr = (wr && addr == `GPG_STCLR) ? wdata[`GPG_NSTAT-1:0] : `GPG_STAT_RST;
   assign irq = |(stat & ien_ff);
   assign pint_irq = pint_flag;
   assign grp_irq = grp_flag;

   // ----------------------------------------------------------------
   // pin interrupt channels
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < `GPG_NCHAN; c = c + 1)
      begin : g_chan
         reg [`GPG_CFG_W-1:0] cfg_ff;
         wire [5:0] sel = cfg_ff[`GPG_CFG_SEL_HI:0];

         always @(posedge clk)
         begin
            if (!rst_b)
               cfg_ff <= `GPG_CFG_RST;
            else if (wr && pint_page && pint_idx == c)
               cfg_ff <= wdata[`GPG_CFG_W-1:0];
         end

         assign cfg_flat[c*`GPG_CFG_W +: `GPG_CFG_W] = cfg_ff;

         gpg_pint_chan u_chan
         (
            .clk(clk),
            .rst_b(rst_b),
            .lvl(lvl[sel]),
            .cfg(cfg_ff),
            .clr(stat_clr[c]),
            .flag(pint_flag[c])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // group interrupt units
   // ----------------------------------------------------------------
   // the combined condition is edge-caught so a long level gives one event
   genvar g;
   generate
      for (g = 0; g < `GPG_NGRP; g = g + 1)
      begin : g_grp
         reg and_ff;
         reg [`GPG_NPIN-1:0] ena_ff;
         reg [`GPG_NPIN-1:0] pol_ff;
         reg cond_ff;
         reg flag_ff;
         wire sel_grp = (addr[13:5] == `GPG_GRP_PAGE + g);
         wire [`GPG_NPIN-1:0] match = ~(lvl ^ pol_ff);
         wire any_hit = |(ena_ff & match);
         wire all_hit = (|ena_ff) & (&(match | ~ena_ff));
         wire cond = and_ff ? all_hit : any_hit;
         wire nxt_flag = (cond & ~cond_ff) | (flag_ff & ~stat_clr[`GPG_NCHAN+g]);

         always @(posedge clk)
         begin
            if (!rst_b)
            begin
               and_ff <= 1'b0;
               ena_ff <= `GPG_PIN_RST;
               pol_ff <= `GPG_PIN_RST;
               cond_ff <= 1'b0;
               flag_ff <= 1'b0;
            end
            else
            begin
               cond_ff <= cond;
               flag_ff <= nxt_flag;
               if (wr && sel_grp)
               begin
                  case (addr[4:2])
                     3'h0: and_ff <= wdata[0];
                     3'h1: ena_ff[31:0] <= wdata;
                     3'h2: ena_ff[63:32] <= wdata;
                     3'h3: pol_ff[31:0] <= wdata;
                     3'h4: pol_ff[63:32] <= wdata;
                     default: and_ff <= and_ff;
                  endcase
               end
            end
         end

         assign grp_flag[g] = flag_ff;
         assign grp_hit_rd[g*32 +: 32] = {31'h0000_0000, sel_grp};
         assign grp_ctrl_rd[g*32 +: 32] =
            (addr[4:2] == 3'h0) ? {31'h0000_0000, and_ff} :
            (addr[4:2] == 3'h1) ? ena_ff[31:0] :
            (addr[4:2] == 3'h2) ? ena_ff[63:32] :
            (addr[4:2] == 3'h3) ? pol_ff[31:0] :
            (addr[4:2] == 3'h4) ? pol_ff[63:32] : `GPG_WORD_RST;
      end
   endgenerate

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // data is registered so it stands in the cycle after the strobe only
   always @*
   begin
      nxt_rdata = `GPG_WORD_RST;
      if (rd)
      begin
         case (addr)
            `GPG_DIR0: nxt_rdata = dir_ff[31:0];
            `GPG_DIR1: nxt_rdata = dir_ff[63:32];
            `GPG_OUT0: nxt_rdata = out_ff[31:0];
            `GPG_OUT1: nxt_rdata = out_ff[63:32];
            `GPG_LVL0: nxt_rdata = lvl[31:0];
            `GPG_LVL1: nxt_rdata = lvl[63:32];
            `GPG_STAT: nxt_rdata = {22'h00_0000, stat};
            `GPG_IEN: nxt_rdata = {22'h00_0000, ien_ff};
            default:
            begin
               if (pin_page)
                  nxt_rdata = {31'h0000_0000, lvl[pin_idx]};
               else if (pint_page)
                  nxt_rdata = {20'h0_0000, cfg_flat[pint_idx*`GPG_CFG_W +: `GPG_CFG_W]};
               else if (grp_hit_rd[0])
                  nxt_rdata = grp_ctrl_rd[31:0];
               else if (grp_hit_rd[32])
                  nxt_rdata = grp_ctrl_rd[63:32];
            end
         endcase
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
         rdata_ff <= `GPG_WORD_RST;
      else
         rdata_ff <= nxt_rdata;
   end

   assign rdata = rdata_ff;

endmodule

// >>> test/gpg_board.sv
`timescale 1ns/1ps
`include "gpg_defines.vh"
module gpg_board
(
   // board levels
   input wire [`GPG_NPIN-1:0] board,
   // device side
   input wire [`GPG_NPIN-1:0] pad_out,
   input wire [`GPG_NPIN-1:0] pad_oe_b,
   output wire [`GPG_NPIN-1:0] pad_in
);
// a driven pin wins over the board, so readback shows the device level
assign pad_in = (pad_out & ~pad_oe_b) | (board & pad_oe_b);
endmodule

// >>> test/gpg_checker.sv
`timescale 1ns/1ps
`include "gpg_defines.vh"
module gpg_checker
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // register port
   input wire [`GPG_AW-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   // pins
   input wire [`GPG_NPIN-1:0] pad_in,
   input wire [`GPG_NPIN-1:0] periph_own,
   input wire [`GPG_NPIN-1:0] pad_out,
   input wire [`GPG_NPIN-1:0] pad_oe_b,
   // interrupts
   input wire [`GPG_NCHAN-1:0] pint_irq,
   input wire [`GPG_NGRP-1:0] grp_irq,
   input wire irq
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
// ----------------------------------------
// port and pin behaviour
// ----------------------------------------
property p_rst;
   $rose(rst_b) |-> pad_oe_b == '1 && pad_out == '0 && pint_irq == '0 && !irq;
endproperty
a_rst: assert property (p_rst) else $error("pins or irq not idle after reset");
property p_dir;
   wr && addr == `GPG_DIR0 |=> pad_oe_b[31:0] == ~($past(wdata) & ~periph_own[31:0]);
endproperty
a_dir: assert property (p_dir) else $error("direction write not applied");
property p_out;
   wr && addr == `GPG_OUT0 |=> pad_out[31:0] == $past(wdata);
endproperty
a_out: assert property (p_out) else $error("port write not applied");
property p_set;
   wr && addr == `GPG_SET0 |=> pad_out[31:0] == ($past(pad_out[31:0]) | $past(wdata));
endproperty
a_set: assert property (p_set) else $error("set write wrong");
property p_clr;
   wr && addr == `GPG_CLR0 |=> pad_out[31:0] == ($past(pad_out[31:0]) & ~$past(wdata));
endproperty
a_clr: assert property (p_clr) else $error("clear write wrong");
property p_pin;
   wr && addr == 14'h10a0 |=> pad_out[40] == $past(wdata[0]) && $stable(pad_out[39:0]);
endproperty
a_pin: assert property (p_pin) else $error("pin word write wrong");
property p_own;
   (~pad_oe_b & periph_own) == '0;
endproperty
a_own: assert property (p_own) else $error("drives a peripheral pin");
property p_rdz;
   !rd |=> rdata == 32'h0;
endproperty
a_rdz: assert property (p_rdz) else $error("read data outside read slot");
// ----------------------------------------
// interrupts
// ----------------------------------------
property p_irq;
   irq |-> pint_irq != '0 || grp_irq != '0;
endproperty
a_irq: assert property (p_irq) else $error("irq without a flag");
property p_gstk;
   grp_irq[0] && !wr |=> grp_irq[0];
endproperty
a_gstk: assert property (p_gstk) else $error("group flag lost");
endmodule

bind gpg_top gpg_checker u_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .pad_in(pad_in), .periph_own(periph_own), .pad_out(pad_out),
   .pad_oe_b(pad_oe_b), .pint_irq(pint_irq), .grp_irq(grp_irq), .irq(irq));

// >>> test/gpio_port_with_pin_group_irq_test.sv
`timescale 1ns/1ps
`include "gpg_defines.vh"
module gpio_port_with_pin_group_irq_test;
logic clk, rst_b, wr, rd;
logic [13:0] addr;
logic [31:0] wdata;
logic [63:0] board, periph_own;
wire [31:0] rdata;
wire [63:0] pad_in, pad_out, pad_oe_b;
wire [7:0] pint_irq;
wire [1:0] grp_irq;
wire irq;
int n_errors, n_tests, cyc;
gpg_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .pad_in(pad_in), .periph_own(periph_own), .pad_out(pad_out),
   .pad_oe_b(pad_oe_b), .pint_irq(pint_irq), .grp_irq(grp_irq), .irq(irq));
gpg_board u_board (.board(board), .pad_out(pad_out), .pad_oe_b(pad_oe_b), .pad_in(pad_in));
initial
begin
   clk = 1'b0;
   forever #12.5 clk = ~clk;
end
// ----------------------------------------
// helpers
// ----------------------------------------
task report_and_stop;
   $display("tests %0d errors %0d", n_tests, n_errors);
   if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
   else
      $display("CHECKS NOT OK");
   $finish;
endtask
task chk(input string nm, input [63:0] got, input [63:0] exp);
   n_tests++;
   if (got !== exp)
   begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
   end
endtask
task bw(input [13:0] a, input [31:0] d);
   @(posedge clk);
   addr <= a;
   wdata <= d;
   wr <= 1'b1;
   @(posedge clk);
   wr <= 1'b0;
   #1;
endtask
task br(input [13:0] a, input [31:0] e, input string nm);
   @(posedge clk);
   addr <= a;
   rd <= 1'b1;
   @(posedge clk);
   rd <= 1'b0;
   #1;
   chk(nm, rdata, e);
endtask
// pin changes land on an edge so the synchroniser count is exact
task pin(input int n, input v, input int w);
   @(posedge clk);
   board[n] <= v;
   repeat (w) @(posedge clk);
   #1;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_reset;
   #1;
   chk("oe_b", pad_oe_b, {64{1'b1}});
   chk("irqs", {pint_irq, grp_irq, irq}, 64'h0);
   br(`GPG_IEN, 32'h0, "ien");
   br(14'h3000, 32'h0, "cfg0");
   $display("reset test done");
endtask
task t_port;
   @(posedge clk);
   periph_own <= 64'h8;
   bw(`GPG_DIR0, 32'hffff_ffff);
   bw(`GPG_OUT0, 32'ha5a5_a5a5);
   bw(`GPG_SET0, 32'hf);
   bw(`GPG_CLR0, 32'hf0);
   chk("out", pad_out[31:0], 32'ha5a5_a50f);
   bw(`GPG_OUT1, 32'h0000_00f0);
   bw(`GPG_SET1, 32'h0000_0003);
   bw(`GPG_CLR1, 32'h0000_0030);
   chk("out1", pad_out[63:32], 32'h0000_00c3);
   chk("oe", pad_oe_b[31:0], 32'h8);
   br(`GPG_OUT0, 32'ha5a5_a50f, "out0");
   br(14'h0ffc, 32'h0, "unmapped");
   bw(`GPG_DIR0, 32'h0);
   chk("oe_in", pad_oe_b[31:0], 32'hffff_ffff);
   $display("port test done");
endtask
task t_pin;
   bw(`GPG_DIR1, 32'h100);
   bw(14'h10a0, 32'h1);
   chk("pin40", pad_out[40], 64'h1);
   pin(45, 1'b1, 4);
   br(14'h10b4, 32'h1, "pin45");
   br(`GPG_LVL1, 32'h2100, "lvl1");
   $display("pin test done");
endtask
task t_pint;
   pin(45, 1'b0, 4);
   bw(14'h3000, 32'h52d);
   bw(`GPG_IEN, 32'h1);
   pin(45, 1'b1, 2);
   chk("early", pint_irq, 64'h0);
   @(posedge clk);
   #1;
   chk("rise", {pint_irq, irq}, 64'h3);
   repeat (4) @(posedge clk);
   bw(`GPG_STCLR, 32'h1);
   chk("clr", {pint_irq, irq}, 64'h0);
   bw(14'h3000, 32'h92d);
   bw(`GPG_STCLR, 32'h1);
   pin(45, 1'b0, 3);
   chk("fall", {pint_irq, irq}, 64'h3);
   bw(14'h3004, 32'hb2d);
   bw(`GPG_STCLR, 32'h1);
   repeat (3) @(posedge clk);
   #1;
   chk("lvl_mask", {pint_irq, irq}, 64'h4);
   bw(14'h3004, 32'h0);
   bw(`GPG_STCLR, 32'h2);
   br(`GPG_STAT, 32'h0, "stat");
   bw(14'h3000, 32'hd2d);
   pin(45, 1'b1, 3);
   chk("both_r", {pint_irq, irq}, 64'h3);
   bw(`GPG_STCLR, 32'h1);
   pin(45, 1'b0, 3);
   chk("both_f", {pint_irq, irq}, 64'h3);
   bw(14'h3000, 32'h0);
   bw(`GPG_STCLR, 32'h1);
   $display("pin irq test done");
endtask
task t_grp;
   // polarity before enables, else low pins match and the condition rises during setup
   bw(14'h3110, 32'h2000);
   bw(14'h3108, 32'h2000);
   bw(14'h3120, 32'h1);
   bw(14'h3130, 32'h6000);
   bw(14'h3128, 32'h6000);
   bw(`GPG_IEN, 32'h200);
   chk("g_idle", {grp_irq, irq}, 64'h0);
   pin(45, 1'b1, 4);
   chk("g_or", {grp_irq, irq}, 64'h2);
   pin(46, 1'b1, 4);
   chk("g_and", {grp_irq, irq}, 64'h7);
   br(`GPG_STAT, 32'h300, "gstat");
   bw(`GPG_STCLR, 32'h300);
   chk("g_clr", {grp_irq, irq}, 64'h0);
   $display("group test done");
endtask
// ----------------------------------------
// run
// ----------------------------------------
always @(posedge clk)
begin
   cyc <= cyc + 1;
   if (cyc == 3000)
   begin
      n_errors++;
      report_and_stop;
   end
end
initial
begin
   {rst_b, wr, rd, addr, wdata, board, periph_own} = '0;
   repeat (16) @(posedge clk);
   rst_b <= 1'b1;
   @(posedge clk);
   t_reset;
   t_port;
   t_pin;
   t_pint;
   t_grp;
   report_and_stop;
end
endmodule
